//--- rtl/mqpc_top.sv
// Outbound list pointers and inbound list entry counters.
// Assumes primary and secondary register ports sampled on i_mclk,
// one-cycle strobes, and list regions sized outside this block.

module mqpc_top #(
    parameter int CNT_W = mqpc_pkg::CNT_W
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Primary register port
    input wire logic i_pri_wr,
    input wire logic i_pri_rd,
    input wire logic [7:0] i_pri_addr,
    input wire logic [31:0] i_pri_wdata,
    output logic [31:0] o_pri_rdata,
    output logic o_pri_rvalid,
    // Secondary register port
    input wire logic i_sec_wr,
    input wire logic i_sec_rd,
    input wire logic [7:0] i_sec_addr,
    input wire logic [31:0] i_sec_wdata,
    output logic [31:0] o_sec_rdata,
    output logic o_sec_rvalid,
    // List region bounds, dword addresses
    input wire logic [29:0] i_out_free_base,
    input wire logic [29:0] i_out_free_last,
    input wire logic [29:0] i_out_post_base,
    input wire logic [29:0] i_out_post_last
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [29:0] out_free_tail;
        logic [29:0] out_post_head;
        logic [31:0] pri_rdata;
        logic pri_rvalid;
        logic [31:0] sec_rdata;
        logic sec_rvalid;
    } mqpc_state_t;

    mqpc_state_t st_r;
    mqpc_state_t st_nxt;

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic mqpc_hit(input logic [7:0] addr, input logic [7:0] off);
        return addr == off;
    endfunction

    function automatic logic [29:0] mqpc_advance(input logic [29:0] ptr,
            input logic [29:0] base, input logic [29:0] last);
        logic [29:0] res;
        res = ptr + 30'h0000_0001;
        if (ptr == last) begin
            res = base;
        end
        return res;
    endfunction

    logic [CNT_W-1:0] cnt_val [mqpc_pkg::NUM_CNT];

    function automatic logic [31:0] mqpc_read(input logic [7:0] addr,
            input logic [29:0] tail, input logic [29:0] head,
            input logic [CNT_W-1:0] post_cnt, input logic [CNT_W-1:0] free_cnt);
        logic [31:0] res;
        res = 32'h0000_0000;
        unique case (addr)
            mqpc_pkg::OFF_OUT_FREE_TAIL: res = {tail, 2'h0};
            mqpc_pkg::OFF_OUT_POST_HEAD: res = {head, 2'h0};
            mqpc_pkg::OFF_IN_POST_CNT: res = {16'h0000, 16'(post_cnt)};
            mqpc_pkg::OFF_IN_FREE_CNT: res = {16'h0000, 16'(free_cnt)};
            default: res = 32'h0000_0000;
        endcase
        return res;
    endfunction

    // ****************************************
    // Access decode
    // ****************************************
    logic pri_in_q_wr;
    logic pri_in_q_rd;
    logic pri_out_q_wr;
    logic pri_out_q_rd;
    logic sec_post_cnt_wr;
    logic sec_free_cnt_wr;
    logic sec_load;

    assign pri_in_q_wr = i_pri_wr && mqpc_hit(i_pri_addr, mqpc_pkg::OFF_IN_QUEUE);
    assign pri_in_q_rd = i_pri_rd && mqpc_hit(i_pri_addr, mqpc_pkg::OFF_IN_QUEUE);
    assign pri_out_q_wr = i_pri_wr && mqpc_hit(i_pri_addr, mqpc_pkg::OFF_OUT_QUEUE);
    assign pri_out_q_rd = i_pri_rd && mqpc_hit(i_pri_addr, mqpc_pkg::OFF_OUT_QUEUE);
    assign sec_post_cnt_wr = i_sec_wr && mqpc_hit(i_sec_addr, mqpc_pkg::OFF_IN_POST_CNT);
    assign sec_free_cnt_wr = i_sec_wr && mqpc_hit(i_sec_addr, mqpc_pkg::OFF_IN_FREE_CNT);
    assign sec_load = i_sec_wdata[mqpc_pkg::LOAD_BIT];

    // ****************************************
    // Entry counters
    // ****************************************
    logic [mqpc_pkg::NUM_CNT-1:0] c_load;
    logic [mqpc_pkg::NUM_CNT-1:0] c_inc;
    logic [mqpc_pkg::NUM_CNT-1:0] c_dec;

    assign c_load[mqpc_pkg::CNT_IN_POST] = sec_post_cnt_wr && sec_load;
    assign c_inc[mqpc_pkg::CNT_IN_POST] = pri_in_q_wr;
    assign c_dec[mqpc_pkg::CNT_IN_POST] = sec_post_cnt_wr && !sec_load;
    assign c_load[mqpc_pkg::CNT_IN_FREE] = sec_free_cnt_wr && sec_load;
    assign c_inc[mqpc_pkg::CNT_IN_FREE] = sec_free_cnt_wr && !sec_load;
    assign c_dec[mqpc_pkg::CNT_IN_FREE] = pri_in_q_rd;

    genvar gi;
    generate
        for (gi = 0; gi < mqpc_pkg::NUM_CNT; gi++) begin : g_cnt
            mqpc_cnt_if #(.WIDTH(CNT_W)) cnt_bus ();

            assign cnt_bus.load = c_load[gi];
            assign cnt_bus.load_val = i_sec_wdata[CNT_W-1:0];
            assign cnt_bus.inc = c_inc[gi];
            assign cnt_bus.dec = c_dec[gi];
            assign cnt_val[gi] = cnt_bus.count;

            mqpc_entry_counter #(
                .WIDTH(CNT_W),
                .FLOOR_AT_ZERO(gi == mqpc_pkg::CNT_IN_FREE)
            ) u_cnt (
                .i_mclk(i_mclk),
                .i_rst(i_rst),
                .cnt_io(cnt_bus.cnt)
            );
        end
    endgenerate

    // ****************************************
    // Pointers and read data
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        if (pri_out_q_wr) begin
            st_nxt.out_free_tail = mqpc_advance(st_r.out_free_tail, i_out_free_base,
                i_out_free_last);
        end
        if (pri_out_q_rd) begin
            st_nxt.out_post_head = mqpc_advance(st_r.out_post_head, i_out_post_base,
                i_out_post_last);
        end
        if (i_sec_wr && mqpc_hit(i_sec_addr, mqpc_pkg::OFF_OUT_FREE_TAIL)) begin
            st_nxt.out_free_tail = i_sec_wdata[31:mqpc_pkg::PTR_LSB];
        end
        if (i_pri_wr && mqpc_hit(i_pri_addr, mqpc_pkg::OFF_OUT_FREE_TAIL)) begin
            st_nxt.out_free_tail = i_pri_wdata[31:mqpc_pkg::PTR_LSB];
        end
        if (i_sec_wr && mqpc_hit(i_sec_addr, mqpc_pkg::OFF_OUT_POST_HEAD)) begin
            st_nxt.out_post_head = i_sec_wdata[31:mqpc_pkg::PTR_LSB];
        end
        if (i_pri_wr && mqpc_hit(i_pri_addr, mqpc_pkg::OFF_OUT_POST_HEAD)) begin
            st_nxt.out_post_head = i_pri_wdata[31:mqpc_pkg::PTR_LSB];
        end
        st_nxt.pri_rvalid = i_pri_rd;
        st_nxt.sec_rvalid = i_sec_rd;
        st_nxt.pri_rdata = mqpc_pkg::RDATA_RST_VAL;
        st_nxt.sec_rdata = mqpc_pkg::RDATA_RST_VAL;
        if (i_pri_rd) begin
            st_nxt.pri_rdata = mqpc_read(i_pri_addr, st_r.out_free_tail, st_r.out_post_head,
                cnt_val[mqpc_pkg::CNT_IN_POST], cnt_val[mqpc_pkg::CNT_IN_FREE]);
        end
        if (i_sec_rd) begin
            st_nxt.sec_rdata = mqpc_read(i_sec_addr, st_r.out_free_tail, st_r.out_post_head,
                cnt_val[mqpc_pkg::CNT_IN_POST], cnt_val[mqpc_pkg::CNT_IN_FREE]);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st_r.out_free_tail <= mqpc_pkg::PTR_RST_VAL;
            st_r.out_post_head <= mqpc_pkg::PTR_RST_VAL;
            st_r.pri_rdata <= mqpc_pkg::RDATA_RST_VAL;
            st_r.pri_rvalid <= 1'b0;
            st_r.sec_rdata <= mqpc_pkg::RDATA_RST_VAL;
            st_r.sec_rvalid <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_pri_rdata = st_r.pri_rdata;
    assign o_pri_rvalid = st_r.pri_rvalid;
    assign o_sec_rdata = st_r.sec_rdata;
    assign o_sec_rvalid = st_r.sec_rvalid;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_tail_step;
        pri_out_q_wr && !i_sec_wr && st_r.out_free_tail != i_out_free_last;
    endsequence

    sequence s_tail_wrap;
        pri_out_q_wr && !i_sec_wr && st_r.out_free_tail == i_out_free_last;
    endsequence

    sequence s_head_step;
        pri_out_q_rd && !i_sec_wr && !i_pri_wr
            && st_r.out_post_head != i_out_post_last;
    endsequence

    sequence s_head_wrap;
        pri_out_q_rd && !i_sec_wr && !i_pri_wr && st_r.out_post_head == i_out_post_last;
    endsequence

    sequence s_free_load;
        sec_free_cnt_wr && sec_load;
    endsequence

    sequence s_free_quiet;
        !sec_free_cnt_wr && !pri_in_q_rd;
    endsequence

    sequence s_free_readback;
        i_pri_rd && !i_pri_wr && !i_sec_wr && i_pri_addr == mqpc_pkg::OFF_IN_FREE_CNT;
    endsequence

    a_tail_advance_one: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        s_tail_step |=> (st_r.out_free_tail == $past(st_r.out_free_tail) + 30'h0000_0001))
        else $error("Free tail did not advance by one dword");

    a_tail_wrap_base: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        s_tail_wrap |=> (st_r.out_free_tail == $past(i_out_free_base)))
        else $error("Free tail did not wrap to base");

    a_head_advance_one: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        s_head_step |=> (st_r.out_post_head == $past(st_r.out_post_head) + 30'h0000_0001))
        else $error("Post head did not advance by one dword");

    a_head_wrap_base: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        s_head_wrap |=> (st_r.out_post_head == $past(i_out_post_base)))
        else $error("Post head did not wrap to base");

    a_ptr_low_zero: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (i_pri_rd && (i_pri_addr == mqpc_pkg::OFF_OUT_FREE_TAIL
            || i_pri_addr == mqpc_pkg::OFF_OUT_POST_HEAD))
        |=> o_pri_rvalid && (o_pri_rdata[1:0] == 2'h0))
        else $error("Pointer readback low bits not zero");

    a_cnt_upper_zero: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (i_sec_rd && (i_sec_addr == mqpc_pkg::OFF_IN_POST_CNT
            || i_sec_addr == mqpc_pkg::OFF_IN_FREE_CNT))
        |=> o_sec_rvalid && (o_sec_rdata[31:16] == 16'h0000))
        else $error("Counter readback upper bits not zero");

    a_post_sec_dec: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (sec_post_cnt_wr && !sec_load && !pri_in_q_wr)
        |=> (cnt_val[mqpc_pkg::CNT_IN_POST]
            == $past(cnt_val[mqpc_pkg::CNT_IN_POST]) - 16'h0001))
        else $error("Post counter did not decrement");

    a_post_pri_inc: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (pri_in_q_wr && !sec_post_cnt_wr)
        |=> (cnt_val[mqpc_pkg::CNT_IN_POST]
            == $past(cnt_val[mqpc_pkg::CNT_IN_POST]) + 16'h0001))
        else $error("Post counter did not increment");

    a_free_sec_inc: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (sec_free_cnt_wr && !sec_load && !pri_in_q_rd)
        |=> (cnt_val[mqpc_pkg::CNT_IN_FREE]
            == $past(cnt_val[mqpc_pkg::CNT_IN_FREE]) + 16'h0001))
        else $error("Free counter did not increment");

    a_free_load_read: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        s_free_load ##1 s_free_quiet ##1 s_free_readback
        |=> (o_pri_rdata == {16'h0000, $past(i_sec_wdata[15:0], 3)}))
        else $error("Free counter load not read back");

    a_count_reset_zero: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        $past(i_rst) |-> (cnt_val[mqpc_pkg::CNT_IN_FREE] == 16'h0000)
            && (cnt_val[mqpc_pkg::CNT_IN_POST] == 16'h0000))
        else $error("Counters not zero after reset");

    a_free_pri_dec: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (pri_in_q_rd && !sec_free_cnt_wr && cnt_val[mqpc_pkg::CNT_IN_FREE] != 16'h0000)
        |=> (cnt_val[mqpc_pkg::CNT_IN_FREE]
            == $past(cnt_val[mqpc_pkg::CNT_IN_FREE]) - 16'h0001))
        else $error("Free counter did not decrement");

    a_post_load_wins: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (sec_post_cnt_wr && sec_load && pri_in_q_wr)
        |=> (cnt_val[mqpc_pkg::CNT_IN_POST] == $past(i_sec_wdata[CNT_W-1:0])))
        else $error("Post counter load lost to an increment");

    a_tail_pri_write: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (i_pri_wr && i_pri_addr == mqpc_pkg::OFF_OUT_FREE_TAIL)
        |=> (st_r.out_free_tail == $past(i_pri_wdata[31:2])))
        else $error("Free tail did not take the written address");

    a_head_sec_write: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (i_sec_wr && i_sec_addr == mqpc_pkg::OFF_OUT_POST_HEAD
            && !(i_pri_wr && i_pri_addr == mqpc_pkg::OFF_OUT_POST_HEAD))
        |=> (st_r.out_post_head == $past(i_sec_wdata[31:2])))
        else $error("Post head did not take the written address");

endmodule // mqpc_top

//--- inc/mqpc_pkg.sv
// Constants for the message queue pointer and counter slice.
// Assumes dword-aligned byte addresses on both register ports.
package mqpc_pkg;

    // ****************************************
    // Register and queue port offsets
    // ****************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_IN_QUEUE = 8'h40;
    localparam logic [7:0] OFF_OUT_QUEUE = 8'h44;
    localparam logic [7:0] OFF_OUT_FREE_TAIL = 8'h50;
    localparam logic [7:0] OFF_OUT_POST_HEAD = 8'h54;
    localparam logic [7:0] OFF_IN_POST_CNT = 8'h58;
    localparam logic [7:0] OFF_IN_FREE_CNT = 8'h5c;

    // ****************************************
    // Field layout
    // ****************************************
    localparam int DATA_W = 32;
    localparam int PTR_LSB = 2;
    localparam int PTR_W = 30;
    localparam int CNT_W = 16;
    localparam int LOAD_BIT = 31;
    localparam int NUM_CNT = 2;
    localparam int CNT_IN_POST = 0;
    localparam int CNT_IN_FREE = 1;

    // ****************************************
    // Values after reset
    // ****************************************
    localparam logic [29:0] PTR_RST_VAL = 30'h0000_0000;
    localparam logic [15:0] CNT_RST_VAL = 16'h0000;
    localparam logic [31:0] RDATA_RST_VAL = 32'h0000_0000;

endpackage : mqpc_pkg

//--- inc/mqpc_cnt_if.sv
// Control and readback of one entry counter.
// Driven by the queue slice top, served by one counter instance.
interface mqpc_cnt_if #(
    parameter int WIDTH = 16
);
    logic load;
    logic [WIDTH-1:0] load_val;
    logic inc;
    logic dec;
    logic [WIDTH-1:0] count;

    // Side that decides the updates
    modport ctl (
        output load,
        output load_val,
        output inc,
        output dec,
        input count
    );

    // Side that holds the count
    modport cnt (
        input load,
        input load_val,
        input inc,
        input dec,
        output count
    );
endinterface : mqpc_cnt_if

//--- rtl/mqpc_entry_counter.sv
// One list entry counter with load, increment and decrement.
// Assumes control strobes synchronous to i_mclk, one cycle each.
module mqpc_entry_counter #(
    parameter int WIDTH = 16,
    parameter bit FLOOR_AT_ZERO = 1'b0
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Counter control
    mqpc_cnt_if.cnt cnt_io
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [WIDTH-1:0] count;
    } mqpc_cnt_state_t;

    mqpc_cnt_state_t st_r;
    mqpc_cnt_state_t st_nxt;
    logic dec_ok;

    assign dec_ok = cnt_io.dec && !(FLOOR_AT_ZERO && (st_r.count == '0));

    // ****************************************
    // Next count
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        if (cnt_io.load) begin
            st_nxt.count = cnt_io.load_val;
        end else if (cnt_io.inc && !dec_ok) begin
            st_nxt.count = st_r.count + WIDTH'(1);
        end else if (!cnt_io.inc && dec_ok) begin
            st_nxt.count = st_r.count - WIDTH'(1);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st_r.count <= WIDTH'(mqpc_pkg::CNT_RST_VAL);
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cnt_io.count = st_r.count;

    // ****************************************
    // Checks
    // ****************************************
    a_cnt_load_value: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        cnt_io.load |=> (cnt_io.count == $past(cnt_io.load_val)))
        else $error("Counter did not take the loaded value");

    a_cnt_zero_floor: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (FLOOR_AT_ZERO && cnt_io.count == '0 && cnt_io.dec && !cnt_io.inc && !cnt_io.load)
        |=> (cnt_io.count == '0))
        else $error("Counter went below zero");

    a_cnt_both_steps: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (cnt_io.inc && cnt_io.dec && !cnt_io.load && cnt_io.count != '0)
        |=> $stable(cnt_io.count))
        else $error("Counter moved on a cancelling step pair");

endmodule // mqpc_entry_counter

//--- tb/mqpc_bus_master.sv
// Partner model: one register bus master for the queue slice.
// Assumes the slice samples strobes on the rising edge of i_mclk.
module mqpc_bus_master (
    // Clock
    input wire logic i_mclk,
    // Request side
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_addr,
    output logic [31:0] o_wdata,
    // Answer side
    input wire logic [31:0] i_rdata,
    input wire logic i_rvalid
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'h00;
        o_wdata = 32'h0000_0000;
    end

    // ****************************************
    // Counter load word
    // ****************************************
    // load with count
    function automatic logic [31:0] load_word(input logic [15:0] v);
        return {1'b1, 15'h2a5a, v};
    endfunction

    // ****************************************
    // One access: drive, hold to the sampling edge, release
    // ****************************************
    task automatic access(input logic w, input logic r, input logic [7:0] a,
                          input logic [31:0] d, output logic [31:0] rd_data,
                          output logic rv);
        @(posedge i_mclk);
        o_wr <= w;
        o_rd <= r;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_mclk);
        o_wr <= 1'b0;
        o_rd <= 1'b0;
        o_wdata <= ~d;
        #1;
        rd_data = i_rdata;
        rv = i_rvalid;
    endtask
endmodule // mqpc_bus_master

//--- tb/tb_mqpc_top.sv
// Self-checking bench for the queue pointer and counter slice.
// Assumes the slice top and its package are compiled before this file.
module tb_mqpc_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic pri_wr, pri_rd, sec_wr, sec_rd, pri_rvalid, sec_rvalid;
    logic [7:0] pri_addr, sec_addr;
    logic [31:0] pri_wdata, sec_wdata, pri_rdata, sec_rdata;
    logic [29:0] free_base = 30'h10, free_last = 30'h13;
    logic [29:0] post_base = 30'h20, post_last = 30'h22;
    logic [31:0] seed = 32'h0001_6a87;
    int num_errors = 0;
    int n_compared = 0;
    int tail, head, post, free;

    always #2.5 i_mclk = ~i_mclk;

    mqpc_top mqpc_top_i (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_pri_wr(pri_wr), .i_pri_rd(pri_rd), .i_pri_addr(pri_addr),
        .i_pri_wdata(pri_wdata), .o_pri_rdata(pri_rdata), .o_pri_rvalid(pri_rvalid),
        .i_sec_wr(sec_wr), .i_sec_rd(sec_rd), .i_sec_addr(sec_addr),
        .i_sec_wdata(sec_wdata), .o_sec_rdata(sec_rdata), .o_sec_rvalid(sec_rvalid),
        .i_out_free_base(free_base), .i_out_free_last(free_last),
        .i_out_post_base(post_base), .i_out_post_last(post_last));
    mqpc_bus_master pri_m (.i_mclk(i_mclk), .o_wr(pri_wr), .o_rd(pri_rd),
        .o_addr(pri_addr), .o_wdata(pri_wdata), .i_rdata(pri_rdata), .i_rvalid(pri_rvalid));
    mqpc_bus_master sec_m (.i_mclk(i_mclk), .o_wr(sec_wr), .o_rd(sec_rd),
        .o_addr(sec_addr), .o_wdata(sec_wdata), .i_rdata(sec_rdata), .i_rvalid(sec_rvalid));

    // ****************************************
    // Reference model
    // ****************************************
    function automatic logic [31:0] mdl_rd(input logic [7:0] a);
        case (a)
            8'h50: return 32'(tail) << 2;
            8'h54: return 32'(head) << 2;
            8'h58: return 32'(post);
            8'h5c: return 32'(free);
            default: return 32'h0000_0000;
        endcase
    endfunction

    task automatic mdl_step(input logic pw, input logic pr, input logic [7:0] pa,
                            input logic [31:0] pd, input logic sw, input logic [7:0] sa,
                            input logic [31:0] sd);
        int inc, dec;
        if (pw && pa == 8'h50) tail = int'(pd[31:2]);
        else if (sw && sa == 8'h50) tail = int'(sd[31:2]);
        else if (pw && pa == 8'h44) tail = (tail == int'(free_last)) ? int'(free_base) : tail + 1;
        if (pw && pa == 8'h54) head = int'(pd[31:2]);
        else if (sw && sa == 8'h54) head = int'(sd[31:2]);
        else if (pr && pa == 8'h44) head = (head == int'(post_last)) ? int'(post_base) : head + 1;
        inc = int'(pw && pa == 8'h40);
        dec = int'(sw && sa == 8'h58 && !sd[31]);
        if (sw && sa == 8'h58 && sd[31]) post = int'(sd[15:0]);
        else post = (post + inc - dec + 65536) % 65536;
        inc = int'(sw && sa == 8'h5c && !sd[31]);
        dec = int'(pr && pa == 8'h40 && free != 0);
        if (sw && sa == 8'h5c && sd[31]) free = int'(sd[15:0]);
        else free = (free + inc - dec) % 65536;
    endtask

    // ****************************************
    // Compare, report, close
    // ****************************************
    task automatic chk_data(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_valid(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic end_sim();
        if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ****************************************
    // One cycle on both ports, checked against the model
    // ****************************************
    task automatic cyc(input logic pw, input logic pr, input logic [7:0] pa,
                       input logic [31:0] pd, input logic sw, input logic sr,
                       input logic [7:0] sa, input logic [31:0] sd);
        logic [31:0] ep, es, gp, gs;
        logic vp, vs;
        ep = pr ? mdl_rd(pa) : 32'h0000_0000;
        es = sr ? mdl_rd(sa) : 32'h0000_0000;
        fork
            pri_m.access(pw, pr, pa, pd, gp, vp);
            sec_m.access(sw, sr, sa, sd, gs, vs);
        join
        chk_valid("pri_rvalid", pr, vp);
        chk_data("pri_rdata", ep, gp);
        chk_valid("sec_rvalid", sr, vs);
        chk_data("sec_rdata", es, gs);
        mdl_step(pw, pr, pa, pd, sw, sa, sd);
    endtask

    task automatic sweep();
        for (int k = 0; k < 4; k++) begin
            cyc(1'b0, 1'b1, 8'h50 + 8'(4 * k), 32'h0, 1'b0, 1'b1, 8'h60 + 8'(4 * k), 32'h0);
        end
    endtask

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic do_reset();
        @(posedge i_mclk);
        i_rst <= 1'b1;
        repeat (5) @(posedge i_mclk);
        i_rst <= 1'b0;
        tail = 0;
        head = 0;
        post = 0;
        free = 0;
    endtask

    initial begin
        repeat (20000) @(posedge i_mclk);
        num_errors++;
        end_sim();
    end

    initial begin
        logic [31:0] r, d;
        do_reset();
        sweep();
        cyc(1'b1, 1'b0, 8'h50, 32'h0000_0043, 1'b0, 1'b0, 8'h00, 32'h0);
        cyc(1'b0, 1'b0, 8'h00, 32'h0, 1'b1, 1'b0, 8'h54, 32'h0000_0082);
        for (int k = 0; k < 6; k++) begin
            cyc(1'b1, 1'b0, 8'h44, rnd(), 1'b0, 1'b1, 8'h50, 32'h0);
        end
        for (int k = 0; k < 5; k++) begin
            cyc(1'b0, 1'b1, 8'h44, 32'h0, 1'b0, 1'b1, 8'h54, 32'h0);
        end
        cyc(1'b0, 1'b0, 8'h00, 32'h0, 1'b1, 1'b0, 8'h58, sec_m.load_word(16'h1234));
        cyc(1'b0, 1'b0, 8'h00, 32'h0, 1'b1, 1'b1, 8'h58, 32'h7fff_ffff);
        for (int k = 0; k < 2; k++) begin
            cyc(1'b1, 1'b0, 8'h40, rnd(), 1'b0, 1'b1, 8'h58, 32'h0);
        end
        cyc(1'b0, 1'b0, 8'h00, 32'h0, 1'b1, 1'b0, 8'h58, sec_m.load_word(16'h0000));
        cyc(1'b0, 1'b0, 8'h00, 32'h0, 1'b1, 1'b0, 8'h58, 32'h0000_0000);
        cyc(1'b0, 1'b0, 8'h00, 32'h0, 1'b1, 1'b1, 8'h5c, sec_m.load_word(16'h0002));
        cyc(1'b0, 1'b1, 8'h5c, 32'h0, 1'b0, 1'b0, 8'h00, 32'h0);
        for (int k = 0; k < 3; k++) begin
            cyc(1'b0, 1'b1, 8'h40, 32'h0, 1'b0, 1'b1, 8'h5c, 32'h0);
        end
        cyc(1'b0, 1'b1, 8'h40, 32'h0, 1'b1, 1'b0, 8'h5c, 32'h0000_0000);
        cyc(1'b1, 1'b0, 8'h40, 32'h0, 1'b1, 1'b0, 8'h58, sec_m.load_word(16'h0007));
        cyc(1'b1, 1'b0, 8'h58, 32'h0000_00ff, 1'b1, 1'b1, 8'h5c, sec_m.load_word(16'hffff));
        sweep();
        for (int i = 0; i < 300; i++) begin
            if (i == 150) begin
                @(posedge i_mclk);
                free_last <= 30'h17;
                post_last <= 30'h25;
            end
            r = rnd();
            d = rnd();
            case (r[2:0] % 3'd6)
                3'd0: cyc(1'b1, 1'b0, 8'h40, d, 1'b0, 1'b0, 8'h00, 32'h0);
                3'd1: cyc(1'b0, 1'b1, 8'h40, d, 1'b0, 1'b0, 8'h00, 32'h0);
                3'd2: cyc(1'b1, 1'b0, 8'h44, d, 1'b0, 1'b0, 8'h00, 32'h0);
                3'd3: cyc(1'b0, 1'b1, 8'h44, d, 1'b0, 1'b0, 8'h00, 32'h0);
                default: cyc(1'b0, 1'b1, {4'h5, r[4:3], 2'b00}, d, 1'b0, 1'b0, 8'h00, 32'h0);
            endcase
            case (r[9:8])
                2'd0: cyc(1'b0, 1'b0, 8'h00, 32'h0, 1'b1, 1'b0, 8'h58, d);
                2'd1: cyc(1'b0, 1'b0, 8'h00, 32'h0, 1'b1, 1'b0, 8'h5c, d);
                2'd2: cyc(1'b1, 1'b0, 8'h40, d, 1'b1, 1'b0, 8'h58, {r[31], d[30:0]});
                default: cyc(1'b0, 1'b1, 8'h40, d, 1'b1, 1'b1, 8'h5c, {r[30], d[30:0]});
            endcase
        end
        do_reset();
        sweep();
        end_sim();
    end
endmodule // tb_mqpc_top
